//--- inc/lcd_pkg.sv
`default_nettype none

package lcd_pkg;

  // timing
  localparam int CLK_PERIOD_NS  = 10;
  localparam int OSC_FREQ_KHZ   = 270;
  localparam int OSC_PERIOD_NS  = 3700;
  localparam int OSC_CYC        = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // memory geometry and addresses
  localparam int       DISP_MEM_DEPTH = 80;
  localparam int       CHARGEN_DEPTH  = 64;
  localparam int       LINE_LEN    = 40;
  localparam int       SCAN_COLS   = 40;
  localparam logic [6:0] LINE1_LAST  = 7'h27;
  localparam logic [6:0] LINE2_BASE  = 7'h40;
  localparam logic [6:0] LINE2_LAST  = 7'h67;
  localparam logic [6:0] ONE_LAST    = 7'h4F;
  localparam logic [7:0] SPACE_CODE  = 8'h20;

  // instruction field positions
  localparam int ENT_ID_BIT    = 1;
  localparam int ENT_SH_BIT    = 0;
  localparam int DSP_ON_BIT    = 2;
  localparam int DSP_CUR_BIT   = 1;
  localparam int DSP_BLK_BIT   = 0;
  localparam int SFT_DISP_BIT  = 3;
  localparam int SFT_RIGHT_BIT = 2;
  localparam int FN_DL_BIT     = 4;
  localparam int FN_N_BIT      = 3;
  localparam int FN_F_BIT      = 2;

  // reset values
  localparam logic RST_INC = 1'b1;

  typedef enum logic [3:0] {
    OP_NONE, OP_CLEAR, OP_HOME, OP_ENTRY, OP_DISP, OP_SHIFT, OP_FUNC, OP_CGADDR, OP_DDADDR
  } op_e;

  function automatic op_e decode_op(input logic [7:0] b);
    op_e o;
    o = OP_NONE;
    if (b[7])
      o = OP_DDADDR;
    else if (b[6])
      o = OP_CGADDR;
    else if (b[5])
      o = OP_FUNC;
    else if (b[4])
      o = OP_SHIFT;
    else if (b[3])
      o = OP_DISP;
    else if (b[2])
      o = OP_ENTRY;
    else if (b[1])
      o = OP_HOME;
    else if (b[0])
      o = OP_CLEAR;
    return o;
  endfunction

  // next address counter value inside display memory layout
  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up, input logic two);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (two) begin
      if (up && a == LINE1_LAST)
        r = LINE2_BASE;
      else if (up && a == LINE2_LAST)
        r = 7'h00;
      else if (!up && a == 7'h00)
        r = LINE2_LAST;
      else if (!up && a == LINE2_BASE)
        r = LINE1_LAST;
    end else begin
      if (up && a == ONE_LAST)
        r = 7'h00;
      else if (!up && a == 7'h00)
        r = ONE_LAST;
    end
    return r;
  endfunction

  // window offset step, wrapping within LINE_LEN with two lines, within DISP_MEM_DEPTH with one
  function automatic logic [6:0] shift_step(input logic [6:0] s, input logic left, input logic two);
    logic [6:0] lim;
    lim = two ? 7'(LINE_LEN) : 7'(DISP_MEM_DEPTH);
    if (left)
      return (s == 7'(lim - 7'h01)) ? 7'h00 : 7'(s + 7'h01);
    return (s == 7'h00) ? 7'(lim - 7'h01) : 7'(s - 7'h01);
  endfunction

  // address counter to physical memory index
  function automatic logic [6:0] ddr_index(input logic [6:0] a, input logic two);
    if (!two)
      return a;
    return a[6] ? 7'(7'(LINE_LEN) + {1'b0, a[5:0]}) : {1'b0, a[5:0]};
  endfunction

endpackage

`default_nettype wire

//--- hw/char_store.sv
`timescale 1ns/1ps
`default_nettype none

module char_store (
  // clock
  input  wire logic       ref_clk,
  // write port
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // host read port
  input  wire logic [6:0] rd_addr_a,
  output logic      [7:0] rd_data_a,
  // scan read port
  input  wire logic [6:0] rd_addr_b,
  output logic      [7:0] rd_data_b
);

  logic [7:0] mem [0:lcd_pkg::DISP_MEM_DEPTH-1];

  // out-of-range writes from odd address sets are dropped; out-of-range reads return a space
  wire wr_ok = wr_en && (wr_addr < 7'(lcd_pkg::DISP_MEM_DEPTH));
  wire rd_ok_a = rd_addr_a < 7'(lcd_pkg::DISP_MEM_DEPTH);
  wire rd_ok_b = rd_addr_b < 7'(lcd_pkg::DISP_MEM_DEPTH);

  always_ff @(posedge ref_clk) begin
    if (wr_ok)
      mem[wr_addr] <= wr_data;
  end

  always_ff @(posedge ref_clk) begin
    rd_data_a <= rd_ok_a ? mem[rd_addr_a] : lcd_pkg::SPACE_CODE;
    rd_data_b <= rd_ok_b ? mem[rd_addr_b] : lcd_pkg::SPACE_CODE;
  end

endmodule // char_store

`default_nettype wire

//--- hw/lcd_instruction_display_control.sv
`timescale 1ns/1ps
`default_nettype none

module lcd_instruction_display_control (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // host pins
  input  wire logic       register_select,
  input  wire logic       read_write,
  input  wire logic       strobe,
  input  wire logic [7:0] data_line_in,
  output logic      [7:0] data_line_out,
  output logic            data_line_oe,
  // mode and status
  output logic            busy,
  output logic            four_bit_mode,
  output logic            two_line_mode,
  output logic            tall_font,
  output logic            display_on,
  output logic            cursor_on,
  output logic            blink_on,
  // display scan
  output logic            scan_tick,
  output logic            scan_line,
  output logic      [5:0] scan_col,
  output logic      [7:0] scan_code,
  output logic            scan_cursor
);

  // pin synchronisers
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  logic        stb_d_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 11'h000;
      sync2_r <= 11'h000;
      stb_d_r <= 1'b0;
    end else begin
      sync1_r <= {register_select, read_write, strobe, data_line_in};
      sync2_r <= sync1_r;
      stb_d_r <= sync2_r[8];
    end
  end

  wire       rs_s  = sync2_r[10];
  wire       rw_s  = sync2_r[9];
  wire       stb_s = sync2_r[8];
  wire [7:0] dat_s = sync2_r[7:0];

  // control state
  logic       four_bit_r, four_bit_nxt;
  logic       phase_r, phase_nxt;
  logic [3:0] hi_nib_r, hi_nib_nxt;
  logic       two_line_r, two_line_nxt;
  logic       font_r, font_nxt;
  logic       disp_r, disp_nxt;
  logic       cur_r, cur_nxt;
  logic       blk_r, blk_nxt;
  logic       id_r, id_nxt;
  logic       es_r, es_nxt;
  logic       dd_sel_r, dd_sel_nxt;
  logic [6:0] ac_r, ac_nxt;
  logic [6:0] shift_r, shift_nxt;
  logic       clearing_r, clearing_nxt;
  logic [6:0] clr_cnt_r, clr_cnt_nxt;

  // access decode; the byte is taken on the strobe's falling edge
  wire       stb_fall  = stb_d_r & ~stb_s;
  wire       take      = stb_fall & ~clearing_r;
  wire       byte_done = take & (~four_bit_r | phase_r);
  wire [7:0] byte_val  = four_bit_r ? {hi_nib_r, dat_s[7:4]} : dat_s;
  wire       inst_go   = byte_done & ~rw_s & ~rs_s;
  wire       data_go   = byte_done & ~rw_s & rs_s;
  wire       read_go   = byte_done & rw_s & rs_s;
  lcd_pkg::op_e op;
  assign op = lcd_pkg::decode_op(byte_val);

  wire [6:0] cg_step = id_r ? 7'({1'b0, ac_r[5:0]} + 7'h01) : 7'({1'b0, ac_r[5:0]} - 7'h01);
  wire [6:0] ac_adv  = dd_sel_r ? lcd_pkg::ac_step(ac_r, id_r, two_line_r) : {1'b0, cg_step[5:0]};
  wire [6:0] ac_idx  = lcd_pkg::ddr_index(ac_r, two_line_r);

  // memory write path, shared between clear engine and data writes
  wire       mem_we = clearing_r | (data_go & dd_sel_r);
  wire [6:0] mem_wa = clearing_r ? clr_cnt_r : ac_idx;
  wire [7:0] mem_wd = clearing_r ? lcd_pkg::SPACE_CODE : byte_val;

  always_comb begin
    four_bit_nxt = four_bit_r;
    phase_nxt    = phase_r;
    hi_nib_nxt   = hi_nib_r;
    two_line_nxt = two_line_r;
    font_nxt     = font_r;
    disp_nxt     = disp_r;
    cur_nxt      = cur_r;
    blk_nxt      = blk_r;
    id_nxt       = id_r;
    es_nxt       = es_r;
    dd_sel_nxt   = dd_sel_r;
    ac_nxt       = ac_r;
    shift_nxt    = shift_r;
    clearing_nxt = clearing_r;
    clr_cnt_nxt  = clr_cnt_r;
    if (clearing_r) begin
      clr_cnt_nxt = 7'(clr_cnt_r + 7'h01);
      if (clr_cnt_r == 7'(lcd_pkg::DISP_MEM_DEPTH - 1))
        clearing_nxt = 1'b0;
    end
    if (take && four_bit_r) begin
      phase_nxt = ~phase_r;
      if (!phase_r)
        hi_nib_nxt = dat_s[7:4];
    end
    if (inst_go) begin
      case (op)
        lcd_pkg::OP_CLEAR: begin
          clearing_nxt = 1'b1;
          clr_cnt_nxt  = 7'h00;
          ac_nxt       = 7'h00;
          shift_nxt    = 7'h00;
          id_nxt       = lcd_pkg::RST_INC;
          dd_sel_nxt   = 1'b1;
        end
        lcd_pkg::OP_HOME: begin
          ac_nxt     = 7'h00;
          shift_nxt  = 7'h00;
          dd_sel_nxt = 1'b1;
        end
        lcd_pkg::OP_ENTRY: begin
          id_nxt = byte_val[lcd_pkg::ENT_ID_BIT];
          es_nxt = byte_val[lcd_pkg::ENT_SH_BIT];
        end
        lcd_pkg::OP_DISP: begin
          disp_nxt = byte_val[lcd_pkg::DSP_ON_BIT];
          cur_nxt  = byte_val[lcd_pkg::DSP_CUR_BIT];
          blk_nxt  = byte_val[lcd_pkg::DSP_BLK_BIT];
        end
        lcd_pkg::OP_SHIFT: begin
          if (byte_val[lcd_pkg::SFT_DISP_BIT])
            shift_nxt = lcd_pkg::shift_step(shift_r, ~byte_val[lcd_pkg::SFT_RIGHT_BIT], two_line_r);
          else
            ac_nxt = lcd_pkg::ac_step(ac_r, byte_val[lcd_pkg::SFT_RIGHT_BIT], two_line_r);
        end
        lcd_pkg::OP_FUNC: begin
          four_bit_nxt = ~byte_val[lcd_pkg::FN_DL_BIT];
          two_line_nxt = byte_val[lcd_pkg::FN_N_BIT];
          font_nxt     = byte_val[lcd_pkg::FN_F_BIT];
          phase_nxt    = 1'b0;
          // offset range depends on line count
          shift_nxt    = 7'h00;
        end
        lcd_pkg::OP_CGADDR: begin
          dd_sel_nxt = 1'b0;
          ac_nxt     = {1'b0, byte_val[5:0]};
        end
        lcd_pkg::OP_DDADDR: begin
          dd_sel_nxt = 1'b1;
          ac_nxt     = byte_val[6:0];
        end
        default: begin
          ac_nxt = ac_r;
        end
      endcase
    end else if (data_go) begin
      ac_nxt = ac_adv;
      if (es_r)
        shift_nxt = lcd_pkg::shift_step(shift_r, id_r, two_line_r);
    end else if (read_go) begin
      // reads step the address but never shift the display
      ac_nxt = ac_adv;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      four_bit_r <= 1'b0;
      phase_r    <= 1'b0;
      hi_nib_r   <= 4'h0;
      two_line_r <= 1'b0;
      font_r     <= 1'b0;
      disp_r     <= 1'b0;
      cur_r      <= 1'b0;
      blk_r      <= 1'b0;
      id_r       <= lcd_pkg::RST_INC;
      es_r       <= 1'b0;
      dd_sel_r   <= 1'b1;
      ac_r       <= 7'h00;
      shift_r    <= 7'h00;
      clearing_r <= 1'b1;
      clr_cnt_r  <= 7'h00;
    end else begin
      four_bit_r <= four_bit_nxt;
      phase_r    <= phase_nxt;
      hi_nib_r   <= hi_nib_nxt;
      two_line_r <= two_line_nxt;
      font_r     <= font_nxt;
      disp_r     <= disp_nxt;
      cur_r      <= cur_nxt;
      blk_r      <= blk_nxt;
      id_r       <= id_nxt;
      es_r       <= es_nxt;
      dd_sel_r   <= dd_sel_nxt;
      ac_r       <= ac_nxt;
      shift_r    <= shift_nxt;
      clearing_r <= clearing_nxt;
      clr_cnt_r  <= clr_cnt_nxt;
    end
  end

  // character generator store; contents undefined until written
  logic [7:0] cg_mem [0:lcd_pkg::CHARGEN_DEPTH-1];
  logic [7:0] cg_rd_r;

  always_ff @(posedge ref_clk) begin
    if (data_go && !dd_sel_r)
      cg_mem[ac_r[5:0]] <= byte_val;
    cg_rd_r <= cg_mem[ac_r[5:0]];
  end

  // scan timing from the internal oscillator rate
  logic [8:0] osc_cnt_r;
  logic       tick_r;
  logic       tick_d_r;
  logic [5:0] col_r;
  logic       line_r;
  logic       scan_cur_r;

  wire       osc_wrap = osc_cnt_r == 9'(lcd_pkg::OSC_CYC - 1);
  wire [6:0] lim      = two_line_r ? 7'(lcd_pkg::LINE_LEN) : 7'(lcd_pkg::DISP_MEM_DEPTH);
  wire [7:0] pos_raw  = 8'({2'b00, col_r} + {1'b0, shift_r});
  wire [7:0] pos_wrap = (pos_raw >= {1'b0, lim}) ? 8'(pos_raw - {1'b0, lim}) : pos_raw;
  // both lines read with the same offset
  wire [6:0] scan_idx = 7'(pos_wrap[6:0] + ((two_line_r && line_r) ? 7'(lcd_pkg::LINE_LEN) : 7'h00));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r  <= 9'h000;
      tick_r     <= 1'b0;
      tick_d_r   <= 1'b0;
      col_r      <= 6'h00;
      line_r     <= 1'b0;
      scan_cur_r <= 1'b0;
    end else begin
      osc_cnt_r <= osc_wrap ? 9'h000 : 9'(osc_cnt_r + 9'h001);
      tick_r    <= osc_wrap;
      tick_d_r  <= tick_r;
      if (osc_wrap) begin
        col_r <= (col_r == 6'(lcd_pkg::SCAN_COLS - 1)) ? 6'h00 : 6'(col_r + 6'h01);
        if (col_r == 6'(lcd_pkg::SCAN_COLS - 1))
          line_r <= two_line_r ? ~line_r : 1'b0;
      end
      scan_cur_r <= cur_r && dd_sel_r && (scan_idx == ac_idx);
    end
  end

  logic [7:0] dd_rd;
  logic [7:0] scan_rd;

  char_store u_store (
    .ref_clk   (ref_clk),
    .wr_en     (mem_we),
    .wr_addr   (mem_wa),
    .wr_data   (mem_wd),
    .rd_addr_a (ac_idx),
    .rd_data_a (dd_rd),
    .rd_addr_b (scan_idx),
    .rd_data_b (scan_rd)
  );

  // read-back: status or memory, lower nibble second in 4-bit mode
  wire [7:0] rd_byte = rs_s ? (dd_sel_r ? dd_rd : cg_rd_r) : {clearing_r, ac_r};
  logic [7:0] dout_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      dout_r <= 8'h00;
    else
      dout_r <= (four_bit_r && phase_r) ? {rd_byte[3:0], 4'h0} : rd_byte;
  end

  assign data_line_out = dout_r;
  assign data_line_oe  = stb_s & rw_s;
  assign busy          = clearing_r;
  assign four_bit_mode = four_bit_r;
  assign two_line_mode = two_line_r;
  assign tall_font     = font_r & ~two_line_r;
  assign display_on    = disp_r;
  assign cursor_on     = cur_r;
  assign blink_on      = blk_r;
  assign scan_tick     = tick_d_r;
  assign scan_line     = line_r;
  assign scan_col      = col_r;
  assign scan_code     = scan_rd;
  assign scan_cursor   = scan_cur_r;

  a_eight_bit_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && !four_bit_r |-> byte_done) else $error("8-bit access did not complete a byte");
  a_nibble_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take && four_bit_r && !phase_r |-> !byte_done ##1 phase_r) else $error("first nibble completed a byte");
  a_mem_range: assert property (@(posedge ref_clk) disable iff (!rst_n)
    clearing_r |-> clr_cnt_r < 7'(lcd_pkg::DISP_MEM_DEPTH)) else $error("clear ran past memory");
  a_shift_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inst_go && op == lcd_pkg::OP_SHIFT && byte_val[lcd_pkg::SFT_DISP_BIT] |-> !mem_we ##1 ac_r == $past(ac_r))
    else $error("display shift touched memory or address");
  a_home_resets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inst_go && op == lcd_pkg::OP_HOME |=> shift_r == 7'h00 && ac_r == 7'h00 && dd_sel_r)
    else $error("return home left offset or address");
  a_line_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_go && dd_sel_r && two_line_r && id_r && ac_r == lcd_pkg::LINE1_LAST |=> ac_r == lcd_pkg::LINE2_BASE)
    else $error("cursor did not move to second line");
  a_shift_window: assert property (@(posedge ref_clk) disable iff (!rst_n)
    two_line_r && !$changed(two_line_r) |-> shift_r < 7'(lcd_pkg::LINE_LEN)) else $error("offset left line");
  a_disp_cursor: assert property (@(posedge ref_clk) disable iff (!rst_n)
    inst_go && byte_val == 8'h0E |=> display_on && cursor_on && !blink_on) else $error("display control wrong");
  a_clear_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(clearing_r) |-> $past(clr_cnt_r) == 7'(lcd_pkg::DISP_MEM_DEPTH - 1)) else $error("clear stopped early");
  a_entry_inc: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_go && dd_sel_r && id_r && !es_r && ac_r < lcd_pkg::LINE1_LAST
    |=> ac_r == 7'($past(ac_r) + 7'h01) && shift_r == $past(shift_r)) else $error("entry increment wrong");
  a_entry_shift: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_go && dd_sel_r && es_r |=> shift_r != $past(shift_r)) else $error("entry shift missing");
  a_data_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
    data_go && dd_sel_r |-> mem_we && mem_wa == ac_idx ##1 ac_r != $past(ac_r)) else $error("data not stored");
  a_osc_spacing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tick_r |=> (!tick_r) [*8]) else $error("scan ticks too close");

endmodule // lcd_instruction_display_control

`default_nettype wire

//--- tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_model (
  // clock
  input  wire logic       ref_clk,
  // device pins
  output logic            register_select,
  output logic            read_write,
  output logic            strobe,
  output logic      [7:0] data_line_in,
  input  wire logic [7:0] data_line_out,
  input  wire logic       busy,
  input  wire logic       data_line_oe,
  // wait limit hit
  output logic            hung
);
  // drive enable seen where read data is taken
  logic oe_q;

  initial begin
    register_select = 1'b0;
    read_write      = 1'b0;
    strobe          = 1'b0;
    data_line_in    = 8'h5A;
    hung            = 1'b0;
    oe_q            = 1'b0;
  end

  // one strobed access; read data taken at the last edge before the fall
  task automatic cycle(input logic rs, input logic rw, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (busy !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 400)
      hung <= 1'b1;
    register_select <= rs;
    read_write      <= rw;
    data_line_in    <= rw ? ~data_line_in : d;
    strobe          <= 1'b1;
    repeat (5) @(posedge ref_clk);
    q = data_line_out;
    oe_q = data_line_oe;
    strobe <= 1'b0;
    // data held past the synchroniser, then released
    repeat (4) @(posedge ref_clk);
    data_line_in <= ~data_line_in;
    repeat (3) @(posedge ref_clk);
  endtask

  // lower lines carry junk in nibble mode: they must be ignored
  task automatic put(input logic rs, input logic [7:0] b, input logic four);
    logic [7:0] q;
    if (four) begin
      cycle(rs, 1'b0, {b[7:4], ~b[3:0]}, q);
      cycle(rs, 1'b0, {b[3:0], ~b[7:4]}, q);
    end else begin
      cycle(rs, 1'b0, b, q);
    end
  endtask

  task automatic get(input logic rs, input logic four, output logic [7:0] v);
    logic [7:0] q;
    cycle(rs, 1'b1, 8'h00, v);
    if (four) begin
      cycle(rs, 1'b1, 8'h00, q);
      v = {v[7:4], q[7:4]};
    end
  endtask
endmodule // host_model

`default_nettype wire

//--- tb/test_lcd_instruction_display_control.sv
`timescale 1ns/1ps
`default_nettype none

module test_lcd_instruction_display_control;
  logic        ref_clk;
  logic        rst_n;
  logic        register_select;
  logic        read_write;
  logic        strobe;
  logic [7:0]  data_line_in;
  logic [7:0]  data_line_out;
  logic        data_line_oe;
  logic        busy;
  logic        four_bit_mode;
  logic        two_line_mode;
  logic        tall_font;
  logic        display_on;
  logic        cursor_on;
  logic        blink_on;
  logic        scan_tick;
  logic        scan_line;
  logic [5:0]  scan_col;
  logic [7:0]  scan_code;
  logic        scan_cursor;
  logic        hung;
  int          errors;
  int          samples_checked;
  logic [31:0] seed;
  logic [7:0]  mem [80];
  logic [6:0]  ac;
  int          off;
  logic        two;
  logic        sh;
  logic        cur;
  logic        four;
  logic [7:0]  v;

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  lcd_instruction_display_control uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .data_line_in(data_line_in), .data_line_out(data_line_out),
    .data_line_oe(data_line_oe), .busy(busy), .four_bit_mode(four_bit_mode),
    .two_line_mode(two_line_mode), .tall_font(tall_font), .display_on(display_on),
    .cursor_on(cursor_on), .blink_on(blink_on), .scan_tick(scan_tick), .scan_line(scan_line),
    .scan_col(scan_col), .scan_code(scan_code), .scan_cursor(scan_cursor)
  );

  host_model host (
    .ref_clk(ref_clk), .register_select(register_select), .read_write(read_write),
    .strobe(strobe), .data_line_in(data_line_in), .data_line_out(data_line_out),
    .data_line_oe(data_line_oe), .busy(busy), .hung(hung)
  );

  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction

  function automatic logic [15:0] flags();
    return {10'h000, four_bit_mode, two_line_mode, tall_font, display_on, cursor_on, blink_on};
  endfunction

  function automatic int idx(input logic [6:0] a);
    if (!two)
      return int'(a);
    return a[6] ? 40 + int'(a[5:0]) : int'(a[5:0]);
  endfunction

  function automatic logic [6:0] nxt(input logic [6:0] a);
    if (two)
      return (a == 7'h27) ? 7'h40 : (a == 7'h67) ? 7'h00 : 7'(a + 7'h01);
    return (a == 7'h4F) ? 7'h00 : 7'(a + 7'h01);
  endfunction

  // both lines share one window offset
  function automatic int pos(input logic ln, input logic [5:0] c);
    return two ? 40 * int'(ln) + (int'(c) + off) % 40 : (int'(c) + off) % 80;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      errors++;
    end
  endtask

  task automatic close_out();
    $display("checks=%0d errors=%0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic hang();
    errors++;
    $display("ERROR t=%0t wait limit got=%h exp=%h", $time, 16'h0001, 16'h0000);
    close_out();
  endtask

  always @(posedge hung) begin
    hang();
  end

  task automatic tend(input string s);
    $display("test %s finished, errors=%0d", s, errors);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (mem[i])
      mem[i] = 8'h20;
    ac = 7'h00;
    off = 0;
    two = 1'b0;
    sh = 1'b0;
    four = 1'b0;
    cur = 1'b0;
    @(posedge ref_clk);
    #1;
    chk({15'h0000, busy}, 16'h0001);
  endtask

  task automatic wr(input logic rs, input logic [7:0] b);
    host.put(rs, b, four);
    chk({15'h0000, host.oe_q}, 16'h0000);
    if (rs) begin
      mem[idx(ac)] = b;
      ac = nxt(ac);
      if (sh)
        off = (off + 1) % (two ? 40 : 80);
    end else if (b[7]) begin
      ac = b[6:0];
    end else if (b == 8'h01) begin
      foreach (mem[i])
        mem[i] = 8'h20;
      ac = 7'h00;
      off = 0;
    end else if (b[7:1] == 7'h01) begin
      ac = 7'h00;
      off = 0;
    end else if (b[7:2] == 6'h01) begin
      sh = b[0];
    end else if (b[7:3] == 5'h01) begin
      cur = b[1];
    end else if (b[7:2] == 6'h05) begin
      ac = nxt(ac);
    end else if (b[7:3] == 5'h03) begin
      off = (off + 1) % (two ? 40 : 80);
    end else if (b[7:5] == 3'h1) begin
      two = b[3];
      off = 0;
    end
  endtask

  task automatic rd(input logic rs);
    host.get(rs, four, v);
    chk({15'h0000, host.oe_q}, 16'h0001);
    if (rs)
      ac = nxt(ac);
  endtask

  task automatic st();
    rd(1'b0);
    chk({8'h00, v}, {9'h000, ac});
  endtask

  // tick spacing and the code shown at each scanned position
  task automatic scan(input int n);
    int cnt;
    int p;
    for (int i = 0; i < n; i++) begin
      cnt = 1;
      @(posedge ref_clk);
      #1;
      while (scan_tick !== 1'b1 && cnt < 400) begin
        @(posedge ref_clk);
        #1;
        cnt++;
      end
      if (cnt >= 400)
        hang();
      if (i > 0)
        chk(16'(cnt), 16'(lcd_pkg::OSC_CYC));
      p = pos(scan_line, scan_col);
      chk({7'h00, scan_cursor, scan_code}, {7'h00, (cur && p == idx(ac)), mem[p]});
    end
  endtask

  initial begin
    errors = 0;
    samples_checked = 0;
    seed = 32'hC19519D6;
    rst_n = 1'b0;
    four = 1'b0;
    do_reset();
    chk(flags(), 16'h0000);
    scan(3);
    wr(1'b0, 8'h30 | (rnd() & 8'h03));
    chk(flags(), 16'h0000);
    wr(1'b0, 8'h0E);
    chk(flags(), 16'h0006);
    wr(1'b0, 8'h06);
    for (int i = 0; i < 8; i++) begin
      wr(1'b1, rnd());
      st();
    end
    scan(3);
    wr(1'b0, 8'hCF);
    wr(1'b1, rnd());
    st();
    wr(1'b0, 8'h07);
    for (int i = 0; i < 3; i++)
      wr(1'b1, rnd());
    scan(3);
    wr(1'b0, 8'h18);
    wr(1'b0, 8'h80);
    for (int i = 0; i < 12; i++) begin
      rd(1'b1);
      chk({8'h00, v}, {8'h00, mem[i]});
    end
    scan(3);
    wr(1'b0, 8'h02);
    st();
    scan(3);
    tend("one_line");
    do_reset();
    wr(1'b0, 8'h3C);
    chk(flags(), 16'h0010);
    wr(1'b0, 8'h06);
    for (int i = 0; i < 40; i++) begin
      wr(1'b1, rnd());
      if (i == 38)
        st();
    end
    st();
    wr(1'b0, 8'hC0);
    for (int i = 0; i < 8; i++)
      wr(1'b1, rnd());
    for (int i = 0; i < 41; i++)
      wr(1'b0, 8'h18);
    wr(1'b0, 8'h0E);
    scan(82);
    tend("two_line");
    do_reset();
    v = rnd();
    host.cycle(1'b0, 1'b0, {4'h2, v[3:0]}, v);
    chk(flags() & 16'h0020, 16'h0020);
    four = 1'b1;
    wr(1'b0, 8'h28);
    chk(flags(), 16'h0030);
    wr(1'b0, 8'h0F);
    chk(flags(), 16'h0037);
    wr(1'b0, 8'h06);
    for (int i = 0; i < 3; i++)
      wr(1'b1, rnd());
    st();
    wr(1'b0, 8'h80);
    for (int i = 0; i < 3; i++) begin
      rd(1'b1);
      chk({8'h00, v}, {8'h00, mem[i]});
    end
    wr(1'b0, 8'h14);
    st();
    wr(1'b0, 8'h01);
    rd(1'b1);
    chk({8'h00, v}, {8'h00, mem[0]});
    st();
    tend("four_bit");
    close_out();
  end
endmodule // test_lcd_instruction_display_control

`default_nettype wire
